// ---- rtl/ubr_consts.vh ----
// Purpose: constants for the break, turnaround and pin-function block
// Assumes: 40 MHz pclk, APB register access
// Notes: register offsets are word indexes; byte address is four times the index
`ifndef UBR_CONSTS_VH
`define UBR_CONSTS_VH
`define UBR_IDX_BREAK 8'h0a
`define UBR_IDX_TURN 8'h0b
`define UBR_IDX_PINSEL 8'h0c
`define UBR_IDX_STATUS 8'h0d
`define UBR_IDX_ERR 8'h0e
`define UBR_BREAK_RST 16'h0000
`define UBR_TURN_RST 16'h0000
`define UBR_PINSEL_RST 16'h0300
`define UBR_BREAK_FOREVER 16'hffff
`define UBR_CLK_HZ 40000000
`define UBR_TICK_MS 1
`define UBR_MS_CYCLES ((`UBR_CLK_HZ / 1000) * `UBR_TICK_MS)
`define UBR_PS_RXTOG 9
`define UBR_PS_TXTOG 8
`define UBR_PS_CLKEN 7
`define UBR_PS_DIR_HI 6
`define UBR_PS_DIR_LO 5
`define UBR_PS_DIRPIN 4
`define UBR_PS_POL 3
`define UBR_PS_MODE_HI 2
`define UBR_PS_MODE_LO 0
`define UBR_MODE_IO 3'h0
`define UBR_MODE_RTSCTS 3'h1
`define UBR_MODE_DTRDSR 3'h2
`define UBR_MODE_EN_TX 3'h3
`define UBR_MODE_EN_ADDR 3'h4
`define UBR_DSEL_IO 2'h0
`define UBR_DSEL_EN_TX 2'h1
`define UBR_DSEL_EN_ADDR 2'h2
`endif

// ---- rtl/ubr_line_ctrl.v ----
// Purpose: tx break generator, rs-485 turnaround delay and pin-function select
// Assumes: uart core supplies char-busy, bit tick, addr match and flow signals
// Notes: APB slave, word registers at index*4
// Notes: countdown reads back live; pins lag their sources by one cycle
// Notes on behaviour
// - all-ones value gives endless break
// - other values count down each millisecond
// - zero count releases the break
// - any write restarts the break command
// - finish current character before break
// - break starts within one millisecond
// - release within two character times
// - wait turnaround bit times before receive
// - bit 9 routes receive toggle pin
// - bit 8 routes transmit toggle pin
// - bit 7 drives clock on pin
// - dedicated select: io, tx, address match
// - bit 4 picks which pin carries enable
// - bit 3 sets enable polarity
// - mode: io, rts/cts, dtr/dsr
// - mode 3/4: enable on tx/address
`include "ubr_consts.vh"
module ubr_line_ctrl #(
  parameter integer MS_CYCLES = `UBR_MS_CYCLES
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // uart core side
  input wire tx_char_busy,
  input wire bit_tick,
  input wire addr_match,
  input wire rts_flow,
  input wire dtr_flow,
  input wire rx_toggle,
  input wire tx_toggle,
  input wire clk_out_src,
  // gpio register outputs for pins not taken by a function
  input wire [9:0] gpio_out,
  // serial and pin outputs
  output reg tx_break,
  output reg shared_handshake_pin,
  output reg shared_pin_func,
  output reg dtr_pin,
  output reg dtr_pin_func,
  output reg dedicated_direction_pin,
  output reg dedicated_pin_func,
  output reg gpio6_pin,
  output reg gpio8_pin,
  output reg gpio9_pin
);
  reg [15:0] break_duration_count_r;
  reg [15:0] turnaround_bit_delay_r;
  reg [15:0] pin_function_select_r;
  reg [3:0] turn_cnt_r;
  reg tx_dir_r;
  reg brk_arm_r;
  reg err_r;
  wire wr_en;
  wire [9:0] idx;
  wire ms_tick;
  wire brk_req;
  wire [2:0] mode_sel;
  wire [1:0] dir_sel;
  wire en_tx_lvl;
  wire en_addr_lvl;

  // register map
  // index 0x0a break count, 0x0b turnaround, 0x0c pin select
  // index 0x0d status (read only), 0x0e reserved-code flag
  // any other index answers with pslverr and is not written

  // word index match against a register index
  function hit;
    input [9:0] a;
    input [7:0] r;
    begin
      hit = (a == {2'h0, r});
    end
  endfunction

  // applies the programmed polarity to an active-high enable
  function pol;
    input en;
    input hi;
    begin
      pol = hi ? en : ~en;
    end
  endfunction

  // apb handshake
  // no wait states: every access completes in its first access cycle
  // pslverr is combinational and only meaningful in the access phase
  // a refused write leaves every register untouched
  assign idx = paddr[11:2];
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign pslverr = psel & penable & ~(hit(idx, `UBR_IDX_BREAK) | hit(idx, `UBR_IDX_TURN) |
    hit(idx, `UBR_IDX_PINSEL) | hit(idx, `UBR_IDX_STATUS) | hit(idx, `UBR_IDX_ERR));

  // the prescaler restarts on every break write, so the first decrement
  // lands a full millisecond after the command; this trades a longer first
  // millisecond for a start one edge after the write when no character is in flight
  // the divider is wide enough for any core clock up to several ghz
  // and costs only a comparator per cycle
  // ms prescaler, realigned on break writes so the 1 ms bound holds
  ubr_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(wr_en & hit(idx, `UBR_IDX_BREAK)),
    .tick(ms_tick)
  );

  // register file
  // only the documented field widths are kept: turnaround keeps four bits and
  // pin select keeps ten; upper bits written by software read back as zero
  // the countdown runs once the break is armed, one edge after the count goes nonzero,
  // so a command written while a character is in flight loses the time spent waiting
  // the all-ones value is a hold code and is never decremented
  // write and countdown can land on the same edge: a write always wins, which is what
  // lets a new command abort the old one on the same edge
  // the reserved-code flag is sticky; if a reserved code is still present
  // when software clears it, the set wins and the flag stays up
  // register writes; countdown shares the break register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_duration_count_r <= `UBR_BREAK_RST;
      turnaround_bit_delay_r <= `UBR_TURN_RST;
      pin_function_select_r <= `UBR_PINSEL_RST;
      err_r <= 1'b0;
    end else begin
      if (wr_en && hit(idx, `UBR_IDX_BREAK))
        break_duration_count_r <= pwdata[15:0];
      else if (ms_tick && brk_arm_r && break_duration_count_r != `UBR_BREAK_FOREVER &&
               break_duration_count_r != 16'h0000)
        break_duration_count_r <= break_duration_count_r - 16'h0001;
      if (wr_en && hit(idx, `UBR_IDX_TURN))
        turnaround_bit_delay_r <= {12'h000, pwdata[3:0]};
      if (wr_en && hit(idx, `UBR_IDX_PINSEL))
        pin_function_select_r <= {6'h00, pwdata[9:0]};
      // sticky flag: reserved codes programmed; set wins over clear on write
      if ((mode_sel > `UBR_MODE_EN_ADDR) || (dir_sel == 2'h3))
        err_r <= 1'b1;
      else if (wr_en && hit(idx, `UBR_IDX_ERR))
        err_r <= 1'b0;
    end
  end

  // read data is captured in the setup cycle of a read, so it is stable
  // through the access phase; a read of the status word therefore reflects
  // the state one cycle before the transfer completes
  // status bits: 0 break level, 1 armed, 2 transmit direction, 3 turn count zero
  // read mux; data registered so prdata comes from flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (hit(idx, `UBR_IDX_BREAK))
        prdata <= {16'h0, break_duration_count_r};
      else if (hit(idx, `UBR_IDX_TURN))
        prdata <= {16'h0, turnaround_bit_delay_r};
      else if (hit(idx, `UBR_IDX_PINSEL))
        prdata <= {16'h0, pin_function_select_r};
      else if (hit(idx, `UBR_IDX_STATUS))
        prdata <= {28'h0, turn_cnt_r == 4'h0, tx_dir_r, brk_arm_r, tx_break};
      else if (hit(idx, `UBR_IDX_ERR))
        prdata <= {31'h0, err_r};
      else
        prdata <= 32'h0;
    end
  end

  // break generator
  // brk_req is high for any nonzero count, hold code included
  // the level is only raised between characters, so a character in flight
  // is shifted out whole; release needs no such wait because the line
  // idles high after the break anyway
  // limitation: if a character starts on the very edge that the break is
  // raised, the uart core must hold it back; this block only sees busy
  // break level: wait for the character in flight, then hold until count is zero
  assign brk_req = (break_duration_count_r != 16'h0000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_arm_r <= 1'b0;
      tx_break <= 1'b0;
    end else begin
      brk_arm_r <= brk_req;
      if (!brk_req)
        tx_break <= 1'b0;
      else if (!tx_char_busy)
        tx_break <= 1'b1;
    end
  end

  // rs-485 turnaround
  // the direction stays on transmit while a character or a break is on the
  // line and reloads the delay each cycle, so the count always starts at
  // the end of the last stop bit
  // the delay counts whole bit ticks; the first tick after busy falls may
  // come early in its bit, so the real hold can be up to one bit short
  // of the programmed delay, plus one cycle
  // transmit direction held for turnaround bit times after the last character
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dir_r <= 1'b0;
      turn_cnt_r <= 4'h0;
    end else begin
      if (tx_char_busy || tx_break) begin
        tx_dir_r <= 1'b1;
        turn_cnt_r <= turnaround_bit_delay_r[3:0];
      end else if (tx_dir_r) begin
        if (turn_cnt_r == 4'h0)
          tx_dir_r <= 1'b0;
        else if (bit_tick)
          turn_cnt_r <= turn_cnt_r - 4'h1;
      end
    end
  end

  // field decode and polarity
  // the enables are built active high and then bent to the programmed
  // polarity, so both pins see the same level for the same condition
  assign mode_sel = pin_function_select_r[`UBR_PS_MODE_HI:`UBR_PS_MODE_LO];
  assign dir_sel = pin_function_select_r[`UBR_PS_DIR_HI:`UBR_PS_DIR_LO];
  assign en_tx_lvl = pol(tx_dir_r, pin_function_select_r[`UBR_PS_POL]);
  assign en_addr_lvl = pol(addr_match, pin_function_select_r[`UBR_PS_POL]);

  // every pin output is registered so that a change of pin select never
  // glitches a pin; the cost is one cycle of lag on every routed signal
  // reserved mode and direction codes fall back to gpio so that a bad
  // write cannot drive a pin that software believed was an input
  // the dtr pin carries dtr_flow only in dtr/dsr mode
  // pin function routing; func high means the pin carries an alternate function
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_handshake_pin <= 1'b0;
      shared_pin_func <= 1'b0;
      dtr_pin <= 1'b0;
      dtr_pin_func <= 1'b0;
      dedicated_direction_pin <= 1'b0;
      dedicated_pin_func <= 1'b0;
      gpio6_pin <= 1'b0;
      gpio8_pin <= 1'b0;
      gpio9_pin <= 1'b0;
    end else begin
      gpio9_pin <= pin_function_select_r[`UBR_PS_RXTOG] ? rx_toggle : gpio_out[9];
      gpio8_pin <= pin_function_select_r[`UBR_PS_TXTOG] ? tx_toggle : gpio_out[8];
      gpio6_pin <= pin_function_select_r[`UBR_PS_CLKEN] ? clk_out_src : gpio_out[6];
      dtr_pin <= (mode_sel == `UBR_MODE_DTRDSR) ? dtr_flow : gpio_out[2];
      dtr_pin_func <= (mode_sel == `UBR_MODE_DTRDSR);
      // shared pin always follows the mode select
      case (mode_sel)
        `UBR_MODE_RTSCTS: begin
          shared_handshake_pin <= rts_flow;
          shared_pin_func <= 1'b1;
        end
        `UBR_MODE_EN_TX: begin
          shared_handshake_pin <= en_tx_lvl;
          shared_pin_func <= 1'b1;
        end
        `UBR_MODE_EN_ADDR: begin
          shared_handshake_pin <= en_addr_lvl;
          shared_pin_func <= 1'b1;
        end
        default: begin
          shared_handshake_pin <= gpio_out[5];
          shared_pin_func <= 1'b0;
        end
      endcase
      if (!pin_function_select_r[`UBR_PS_DIRPIN]) begin
        dedicated_direction_pin <= gpio_out[7];
        dedicated_pin_func <= 1'b0;
      end else begin
        case (dir_sel)
          `UBR_DSEL_EN_TX: begin
            dedicated_direction_pin <= en_tx_lvl;
            dedicated_pin_func <= 1'b1;
          end
          `UBR_DSEL_EN_ADDR: begin
            dedicated_direction_pin <= en_addr_lvl;
            dedicated_pin_func <= 1'b1;
          end
          default: begin
            dedicated_direction_pin <= gpio_out[7];
            dedicated_pin_func <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // ubr_line_ctrl

// ---- rtl/ubr_ms_tick.v ----
// Purpose: millisecond tick prescaler from the core clock
// Assumes: pclk at the rate in the constants header
// Notes: tick is a one-cycle pulse; restart realigns the millisecond window
`include "ubr_consts.vh"
module ubr_ms_tick #(
  parameter integer MS_CYCLES = `UBR_MS_CYCLES
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire restart,
  output reg tick
);
  reg [31:0] cnt_r;

  // free-running divider, restarted on a new break command
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r == MS_CYCLES - 1) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // ubr_ms_tick

// ---- test/ubr_far_model.sv ----
// Purpose: remote serial side: bit clock, character shifter, break watch
// Assumes: four pclk cycles per bit, ten bits per character
// Notes: busy rises the edge after start and spans ten bit ticks
module ubr_far_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // line
  input wire start,
  input wire tx_break,
  output logic bit_tick,
  output logic tx_char_busy,
  output int brk_cycles
);
  logic [1:0] div_r;
  logic [3:0] bits_r;
  // bit clock runs free; a stop bit never shortens, so ten full ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      bits_r <= 4'h0;
      bit_tick <= 1'b0;
      tx_char_busy <= 1'b0;
      brk_cycles <= 0;
    end else begin
      div_r <= div_r + 2'h1;
      bit_tick <= div_r == 2'h3;
      brk_cycles <= brk_cycles + int'(tx_break);
      if (start) tx_char_busy <= 1'b1;
      if (start) bits_r <= 4'h0;
      else if (tx_char_busy && bit_tick) bits_r <= bits_r + 4'h1;
      if (tx_char_busy && bit_tick && bits_r == 4'h9) tx_char_busy <= 1'b0;
    end
  end
endmodule // ubr_far_model

// ---- test/ubr_line_ctrl_bench.sv ----
// Purpose: self-checking bench for the line control block
// Assumes: one bit is four cycles, a millisecond is MS cycles
// Notes: flow, toggle, match and gpio inputs are random every cycle; busy and bit tick come from the far model
module ubr_line_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, s;
  logic addr_match = 0, rts_flow = 0, dtr_flow = 0, rx_toggle = 0, tx_toggle = 0;
  logic clk_out_src = 0;
  logic [9:0] gpio_out = 0;
  logic [12:0] q;
  wire pready, pslverr, tx_break, bit_tick, tx_char_busy, shared_handshake_pin, shared_pin_func;
  wire dtr_pin, dtr_pin_func, dedicated_direction_pin, dedicated_pin_func, gpio6_pin;
  wire gpio8_pin, gpio9_pin;
  wire [31:0] prdata;
  int brk_cycles, n_errors = 0, comparisons = 0, n, b;
  ubr_line_ctrl #(.MS_CYCLES(MS)) ubr_line_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .tx_char_busy, .bit_tick, .addr_match,
    .rts_flow, .dtr_flow, .rx_toggle, .tx_toggle, .clk_out_src, .gpio_out, .tx_break,
    .shared_handshake_pin, .shared_pin_func, .dtr_pin, .dtr_pin_func, .dedicated_direction_pin,
    .dedicated_pin_func, .gpio6_pin, .gpio8_pin, .gpio9_pin);
  ubr_far_model ubr_far_model_i (.pclk, .presetn, .start, .tx_break, .bit_tick, .tx_char_busy,
    .brk_cycles);
  always #12.5 pclk = ~pclk;
  // random core inputs, plus a copy one edge old for pin expectations
  always @(posedge pclk) begin
    {gpio_out, rx_toggle, tx_toggle, clk_out_src, addr_match, rts_flow, dtr_flow} <= 16'($urandom);
    q <= {gpio_out, rx_toggle, tx_toggle, clk_out_src};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic char_out();
    start <= 1;
    @(posedge pclk) start <= 0;
  endtask
  task final_report;
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog well beyond the thousand or fewer cycles the tests take
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    final_report();
  end
  initial begin
    n = $urandom(32'hb7fd63ce);
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 10'h00a, 0); chk(rd, 0);
    apb(0, 10'h00b, 0); chk(rd, 0);
    apb(0, 10'h00c, 0); chk(rd, 32'h300);
    apb(0, 10'h030, 0); chk(err, 1);
    for (int i = 0; i < 8; i++) begin
      s = i << 7;
      apb(1, 10'h00c, s); apb(0, 10'h00c, 0); chk(rd, s);
      @(negedge pclk);
      chk(gpio9_pin, s[9] ? q[2] : q[12]);
      chk(gpio8_pin, s[8] ? q[1] : q[11]);
      chk(gpio6_pin, s[7] ? q[0] : q[9]);
    end
    for (int m = 0; m < 5; m++) begin
      apb(1, 10'h00c, m); @(negedge pclk);
      chk(shared_pin_func, m == 1 || m == 3 || m == 4);
      chk(dtr_pin_func, m == 2);
      if (m == 0) chk(shared_handshake_pin, q[8]);
      if (m == 3) chk(shared_handshake_pin, 1);
      if (m != 2) chk(dtr_pin, q[5]);
    end
    for (int d = 0; d < 6; d++) begin
      s = 32'h10 | (d % 3) << 5 | (d / 3) << 3;
      apb(1, 10'h00c, s); apb(1, 10'h00b, d * 3); @(negedge pclk);
      chk(dedicated_pin_func, d % 3 != 0);
      if (d % 3 == 1) begin
        chk(dedicated_direction_pin, d < 3);
        char_out();
        repeat (8) @(negedge pclk);
        chk(dedicated_direction_pin, d >= 3);
        n = 0;
        while (tx_char_busy === 1'b1 && n < 100) begin @(negedge pclk); n++; end
        n = 0;
        while (dedicated_direction_pin !== (d < 3) && n < 100) begin @(negedge pclk); n++; end
        chk(n >= d * 12 && n <= d * 12 + 6, 1);
      end
    end
    apb(1, 10'h00c, 32'h300);
    n = $urandom_range(4, 2);
    b = brk_cycles;
    apb(1, 10'h00a, n);
    repeat (MS + 4) @(posedge pclk);
    apb(0, 10'h00a, 0); chk(rd, n - 1);
    repeat (n * MS + 60) @(posedge pclk);
    chk(tx_break, 0);
    chk(brk_cycles - b >= n * MS - 2 && brk_cycles - b <= n * MS + MS + 80, 1);
    apb(1, 10'h00a, 5);
    repeat (MS) @(posedge pclk);
    apb(1, 10'h00a, 16'hffff);
    repeat (10 * MS) @(posedge pclk);
    apb(0, 10'h00a, 0); chk(rd, 16'hffff); chk(tx_break, 1);
    apb(1, 10'h00a, 1);
    repeat (2 * MS + 90) @(posedge pclk);
    chk(tx_break, 0);
    char_out();
    apb(1, 10'h00a, 3); @(negedge pclk);
    chk(tx_break, 0);
    repeat (50) @(posedge pclk);
    chk(tx_break, 1);
    apb(1, 10'h00a, 0); @(negedge pclk);
    repeat (3) @(negedge pclk);
    chk(tx_break, 0);
    final_report();
  end
endmodule // ubr_line_ctrl_bench

// ---- test/ubr_line_monitor.sv ----
// Purpose: port checker for the line control block
// Assumes: pin select mirrored from apb writes
// Notes: pin outputs are judged one edge after their cause
module ubr_line_monitor (
  // clock and apb
  input wire pclk, input wire presetn, input wire psel, input wire penable,
  input wire pwrite, input wire [11:0] paddr, input wire [31:0] pwdata,
  // uart core side and pins
  input wire tx_char_busy, input wire rx_toggle, input wire tx_toggle, input wire clk_out_src,
  input wire [9:0] gpio_out, input wire tx_break, input wire dedicated_pin_func,
  input wire gpio6_pin, input wire gpio8_pin, input wire gpio9_pin
);
  wire wr = psel && penable && pwrite;
  wire brk_wr = wr && paddr[11:2] == 10'h00a;
  reg [9:0] sel_r;
  reg endless_r;
  // expected pin values from the mirrored select
  wire e9 = sel_r[9] ? rx_toggle : gpio_out[9];
  wire e8 = sel_r[8] ? tx_toggle : gpio_out[8];
  wire e6 = sel_r[7] ? clk_out_src : gpio_out[6];
  wire ed = sel_r[4] && (sel_r[6:5] == 2'h1 || sel_r[6:5] == 2'h2);
  // mirror follows the write edge, as the register does
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 10'h300;
      endless_r <= 1'b0;
    end else begin
      if (wr && paddr[11:2] == 10'h00c) sel_r <= pwdata[9:0];
      if (brk_wr) endless_r <= pwdata[15:0] == 16'hffff;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rx; $past(presetn) |-> gpio9_pin == $past(e9); endproperty
  a_rx: assert property (p_rx) else $error("gpio9 routing wrong");
  property p_tx; $past(presetn) |-> gpio8_pin == $past(e8); endproperty
  a_tx: assert property (p_tx) else $error("gpio8 routing wrong");
  property p_clk; $past(presetn) |-> gpio6_pin == $past(e6); endproperty
  a_clk: assert property (p_clk) else $error("gpio6 routing wrong");
  property p_ded; $past(presetn) |-> dedicated_pin_func == $past(ed); endproperty
  a_ded: assert property (p_ded) else $error("direction pin function wrong");
  property p_busy; $rose(tx_break) |-> !$past(tx_char_busy); endproperty
  a_busy: assert property (p_busy) else $error("break cut a character");
  property p_start;
    brk_wr && pwdata[15:0] != 16'h0 && !tx_char_busy ##1 !tx_char_busy [*3] |-> ##[0:2] tx_break;
  endproperty
  a_start: assert property (p_start) else $error("break late");
  property p_stop; brk_wr && pwdata[15:0] == 16'h0 |-> ##[1:3] !tx_break; endproperty
  a_stop: assert property (p_stop) else $error("break not released");
  property p_endless; endless_r && $past(tx_break) |-> tx_break; endproperty
  a_endless: assert property (p_endless) else $error("endless break ended");
  c_on: cover property ($rose(tx_break));
  c_endless: cover property (endless_r && tx_break);
  c_ded: cover property (dedicated_pin_func);
endmodule // ubr_line_monitor
bind ubr_line_ctrl ubr_line_monitor ubr_line_monitor_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .tx_char_busy, .rx_toggle, .tx_toggle, .clk_out_src, .gpio_out,
  .tx_break, .dedicated_pin_func, .gpio6_pin, .gpio8_pin, .gpio9_pin);
